// ==== rtl/fdc_byte_store.sv ====
// indexed byte array holding the command bytes of one command
// assumes writes arrive one byte per cycle at most
`timescale 1ns/10ps
`default_nettype none
module fdc_byte_store #(
  parameter int DEPTH = 9
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  output logic [DEPTH-1:0][7:0] bytes
);
  // flip-flop storage, cleared only by hard reset, so bytes of an earlier command stay in slots a shorter command does not write
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      bytes <= '0;
    else if (we && int'(waddr) < DEPTH)
      bytes[waddr] <= wdata;
  end
endmodule : fdc_byte_store
`default_nettype wire

// ==== rtl/fdc_cmd_pkg.sv ====
// constants, types and command table for the floppy command sequencer
// assumes a 32-bit avalon-mm register bus and byte-wide command traffic
package fdc_cmd_pkg;
  // register byte addresses
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  // main status bit positions
  localparam int MSR_RQM = 7;
  localparam int MSR_DIO = 6;
  localparam int MSR_EXEC = 5;
  localparam int MSR_BUSY = 4;
  localparam int MSR_CYLHI = 3;
  // control register fields
  localparam int CTRL_SOFT_RESET = 0;
  localparam int CTRL_CYL_EXT = 16;
  localparam int CTRL_THR_LSB = 8;
  localparam int CTRL_FIFO_ENABLE_BIT = 12;
  localparam int CTRL_LOCK = 13;
  localparam int CTRL_WG = 14;
  // command and parameter byte fields, command codes
  localparam int BIT_MT = 7;
  localparam int BIT_DD = 6;
  localparam int BIT_SK = 5;
  localparam int BIT_LOCK = 7;
  localparam int BIT_HDS = 2;
  localparam logic [4:0] OP_READ_DATA = 5'h06;
  localparam logic [4:0] OP_READ_DELETED = 5'h0C;
  localparam logic [4:0] OP_PERPENDICULAR = 5'h12;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam logic [4:0] OP_LOCK = 5'h14;
  localparam int CFG_FIFO_ENABLE_BIT_BIT = 5;
  localparam int PERP_WG_BIT = 0;
  // parameter byte slots
  localparam int P_DRIVE = 1;
  localparam int P_CYL = 2;
  localparam int P_HEAD = 3;
  localparam int P_REC = 4;
  localparam int P_SIZE = 5;
  localparam int P_EOT = 6;
  localparam int P_DTL = 8;
  localparam int P_CFG = 2;
  localparam int P_PRECOMP_START_TRACK = 3;
  // result byte slots
  localparam int R_ST0 = 0;
  localparam int R_ST1 = 1;
  localparam int R_ST2 = 2;
  localparam int R_CYL = 3;
  localparam int R_HEAD = 4;
  localparam int R_REC = 5;
  localparam int R_SIZE = 6;
  // status values
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] ST1_OVERRUN = 8'h10;
  localparam logic [7:0] ST2_CTRL_MARK = 8'h40;
  // reset values of the lockable settings
  localparam logic [3:0] THR_RESET = 4'h0;
  localparam logic [7:0] PRECOMP_START_TRACK_RESET = 8'h00;
  localparam int NUM_COMMANDS = 20;
  localparam int CMD_BYTES_MAX = 9;
  localparam int SEC_BASE_SHIFT = 7;

  typedef enum logic [1:0] {PH_GATHER, PH_EXEC, PH_RESULT} phase_t;

  typedef struct packed {
    logic valid;
    logic [3:0] cmdLen;
    logic [3:0] resLen;
    logic diskRead;
  } cmd_info_t;

  // byte counts per command code, command byte included
  function automatic cmd_info_t cmd_info(input logic [4:0] op);
    cmd_info_t i;
    i = '{valid: 1'b1, cmdLen: 4'h9, resLen: 4'h7, diskRead: 1'b0};
    unique case (op)
      5'h06, 5'h0C: i.diskRead = 1'b1;
      5'h05, 5'h09, 5'h02, 5'h16, 5'h11, 5'h19, 5'h1D: ;
      5'h0A: i.cmdLen = 4'h2;
      5'h0D: i.cmdLen = 4'h6;
      5'h07, 5'h12: i = '{1'b1, 4'h2, 4'h0, 1'b0};
      5'h08: i = '{1'b1, 4'h1, 4'h2, 1'b0};
      5'h03, 5'h0F: i = '{1'b1, 4'h3, 4'h0, 1'b0};
      5'h04: i = '{1'b1, 4'h2, 4'h1, 1'b0};
      5'h13: i = '{1'b1, 4'h4, 4'h0, 1'b0};
      5'h0E: i = '{1'b1, 4'h1, 4'hA, 1'b0};
      5'h10, 5'h14: i = '{1'b1, 4'h1, 4'h1, 1'b0};
      default: i = '{1'b0, 4'h1, 4'h1, 1'b0};
    endcase
    return i;
  endfunction : cmd_info

  // data bytes per sector from the size code
  function automatic logic [15:0] sector_bytes(input logic [2:0] n,
                                               input logic [7:0] data_length_param);
    sector_bytes = (n == 3'h0) ? {8'h00, data_length_param}
                 : 16'(32'd1 << (SEC_BASE_SHIFT + int'(n)));
  endfunction : sector_bytes
endpackage : fdc_cmd_pkg

// ==== rtl/fdc_exec_if.sv ====
// link between the phase engine and the disk read execution unit
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none
interface fdc_exec_if;
  logic start;
  logic wantDeleted;
  logic skip;
  logic [2:0] sizeCode;
  logic [7:0] data_length_param;
  logic [7:0] firstRec;
  logic [7:0] lastRec;
  logic [7:0] endRec;
  logic done;
  logic overrun;
  logic ctrlMark;
  logic [7:0] hostByte;
  logic hostFull;
  logic hostTake;
  modport engine (output start, wantDeleted, skip, sizeCode, data_length_param, firstRec,
    lastRec, hostTake, input endRec, done, overrun, ctrlMark, hostByte,
    hostFull);
  modport exec (input start, wantDeleted, skip, sizeCode, data_length_param, firstRec,
    lastRec, hostTake, output endRec, done, overrun, ctrlMark, hostByte,
    hostFull);
endinterface : fdc_exec_if
`default_nettype wire

// ==== rtl/fdc_read_exec.sv ====
// execution unit for the two read commands: walks sectors, hands bytes on
// assumes the drive side gives secStart pulses then byte-valid strobes
`timescale 1ns/10ps
`default_nettype none
module fdc_read_exec (
  input wire logic core_clk,
  input wire logic rstn,
  fdc_exec_if.exec ex,
  input wire logic secStart,
  input wire logic secDeleted,
  input wire logic [7:0] diskByte,
  input wire logic diskValid,
  output logic diskReadActive
);
  typedef enum logic [1:0] {X_IDLE, X_WAIT, X_XFER, X_DRAIN} xstate_t;
  xstate_t state;
  logic [15:0] cnt;
  logic passSec;
  logic markSec;

  wire logic [15:0] secLen = fdc_cmd_pkg::sector_bytes(ex.sizeCode, ex.data_length_param);
  wire logic lastByte = diskValid && (cnt == secLen - 16'h0001);
  wire logic overrunNow = diskValid && passSec && ex.hostFull
                          && !ex.hostTake;
  assign diskReadActive = (state == X_WAIT) || (state == X_XFER);
  assign ex.done = (state == X_DRAIN) && !ex.hostFull;

  // sector walk; an overrun ends the transfer at once
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state <= X_IDLE;
      cnt <= '0;
      passSec <= 1'b0;
      markSec <= 1'b0;
      ex.endRec <= '0;
      ex.overrun <= 1'b0;
      ex.ctrlMark <= 1'b0;
    end
    else
    begin
      unique case (state)
        X_IDLE:
          if (ex.start)
          begin
            state <= X_WAIT;
            ex.endRec <= ex.firstRec;
            ex.overrun <= 1'b0;
            ex.ctrlMark <= 1'b0;
          end
        X_WAIT:
          if (secStart)
          begin
            state <= X_XFER;
            cnt <= '0;
            markSec <= secDeleted != ex.wantDeleted;
            passSec <= (secDeleted == ex.wantDeleted) || !ex.skip;
          end
        X_XFER:
          if (overrunNow)
          begin
            ex.overrun <= 1'b1;
            state <= X_DRAIN;
          end
          else if (lastByte)
          begin
            cnt <= '0;
            if (markSec && passSec)
            begin
              ex.ctrlMark <= 1'b1;
              state <= X_DRAIN;
            end
            else if (ex.endRec == ex.lastRec)
              state <= X_DRAIN;
            else
            begin
              ex.endRec <= ex.endRec + 8'h01;
              state <= X_WAIT;
            end
          end
          else if (diskValid)
            cnt <= cnt + 16'h0001;
        X_DRAIN:
          if (!ex.hostFull)
            state <= X_IDLE;
      endcase
    end
  end

  // one-byte holding stage toward the host; a new byte wins over a take
  always_ff @(posedge core_clk)
  begin
    if (!rstn || ex.start)
    begin
      ex.hostFull <= 1'b0;
      ex.hostByte <= '0;
    end
    else if (state == X_XFER && diskValid && passSec && !overrunNow)
    begin
      ex.hostFull <= 1'b1;
      ex.hostByte <= diskByte;
    end
    else if (ex.hostTake)
      ex.hostFull <= 1'b0;
  end
endmodule : fdc_read_exec
`default_nettype wire

// ==== rtl/floppy_cmd_phase_engine.sv ====
// floppy controller command sequencer: command, execution, result phases
// assumes an avalon-mm master with waitrequest and a drive-side byte stream
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - twenty-one command codes are recognised from the first byte written.
// - each valid command runs gather, then execute, then result phase if it has result bytes; an invalid code goes from gather to result.
// - execution runs the reads, configure, lock and perpendicular with the gathered parameters; other codes end at once.
// - after execution, status and housekeeping bytes wait for host reads.
// - read command byte holds multitrack, density and skip in bits 7..5.
// - second byte holds head select bit 2 and drive select bits 1..0.
// - read commands take nine bytes, code through data length.
// - read results are three status bytes then cylinder, head, record, size.
// - with skip set, sectors of the other mark kind are skipped.
// - cylinder values run from 0 up to 511.
// - size code fixes the data bytes per sector; code 0 takes the data length byte instead.
// - with lock on, fifo and precompensation settings survive soft reset.
// - a stored start track selects where precompensation begins.
// - write gate setting changes write enable timing toward the drive.
// - request and direction status bits pace every byte transfer.
// - entering execution flushes the data fifo.
// - overrun ends the command; host drains data before results.
module floppy_cmd_phase_engine (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic secStart,
  input wire logic secDeleted,
  input wire logic [7:0] diskByte,
  input wire logic diskValid,
  input wire logic writeGateReq,
  output logic diskReadActive,
  output logic writeEnable,
  output logic precompEnable,
  output logic fifoFlush,
  output logic fifoEnable,
  output logic [3:0] fifoThreshold,
  output logic [1:0] driveSelect,
  output logic headSelect
);
  fdc_cmd_pkg::phase_t phase;
  fdc_cmd_pkg::cmd_info_t info;
  logic served;
  logic [3:0] cmdIdx;
  logic [3:0] resIdx;
  logic [3:0] resLen;
  logic [7:0] cmdCode;
  logic [7:0] st0;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [8:0] cylinder;
  logic [7:0] headNum;
  logic [7:0] record;
  logic [7:0] sizeCode;
  logic cylExt;
  logic lockOn;
  logic [7:0] precompTrack;
  logic writeGateTiming;
  logic weDelayed;
  logic execWait;
  logic [fdc_cmd_pkg::CMD_BYTES_MAX-1:0][7:0] cmdBytes;

  fdc_exec_if ex ();

  // bus decode: one wait cycle, then the access completes
  wire logic req = read || write;
  wire logic acc = req && served;
  wire logic selData = address == fdc_cmd_pkg::OFS_DATA;
  wire logic selCtrl = address == fdc_cmd_pkg::OFS_CTRL;
  wire logic selStat = address == fdc_cmd_pkg::OFS_STATUS;
  wire logic [7:0] wByte = writedata[7:0];
  wire logic request_for_master = (phase == fdc_cmd_pkg::PH_GATHER)
                || (phase == fdc_cmd_pkg::PH_RESULT)
                || (phase == fdc_cmd_pkg::PH_EXEC && ex.hostFull);
  wire logic transfer_direction_bit = phase != fdc_cmd_pkg::PH_GATHER;
  wire logic hostWr = acc && write && selData && request_for_master && !transfer_direction_bit;
  wire logic hostRd = acc && read && selData && request_for_master && transfer_direction_bit;
  wire logic softRst = acc && write && selCtrl
                       && writedata[fdc_cmd_pkg::CTRL_SOFT_RESET];
  wire logic ctrlWr = acc && write && selCtrl;
  wire fdc_cmd_pkg::cmd_info_t newInfo = fdc_cmd_pkg::cmd_info(wByte[4:0]);
  wire logic firstByte = hostWr && cmdIdx == 4'h0;
  wire logic lastParam = hostWr && (firstByte ? newInfo.cmdLen == 4'h1
                                              : cmdIdx + 4'h1 == info.cmdLen);
  wire logic badCode = firstByte && !newInfo.valid;
  wire logic enterExec = lastParam && !badCode;
  wire logic lastRes = hostRd && phase == fdc_cmd_pkg::PH_RESULT
                       && resIdx + 4'h1 >= resLen;
  wire logic [4:0] op = cmdCode[4:0];
  wire logic isRead = op == fdc_cmd_pkg::OP_READ_DATA
                   || op == fdc_cmd_pkg::OP_READ_DELETED;
  assign waitrequest = req && !served;

  // hand-off to the read unit; bytes come straight from the store
  assign ex.start = execWait && isRead;
  assign ex.wantDeleted = op == fdc_cmd_pkg::OP_READ_DELETED;
  assign ex.skip = cmdCode[fdc_cmd_pkg::BIT_SK];
  assign ex.sizeCode = cmdBytes[fdc_cmd_pkg::P_SIZE][2:0];
  assign ex.data_length_param = cmdBytes[fdc_cmd_pkg::P_DTL];
  assign ex.firstRec = cmdBytes[fdc_cmd_pkg::P_REC];
  assign ex.lastRec = cmdBytes[fdc_cmd_pkg::P_EOT];
  assign ex.hostTake = hostRd && phase == fdc_cmd_pkg::PH_EXEC;

  fdc_byte_store #(.DEPTH(fdc_cmd_pkg::CMD_BYTES_MAX)) u_store (
    .core_clk(core_clk),
    .rstn(rstn),
    .we(hostWr),
    .waddr(cmdIdx),
    .wdata(wByte),
    .bytes(cmdBytes)
  );

  fdc_read_exec u_exec (
    .core_clk(core_clk),
    .rstn(rstn && !softRst),
    .ex(ex),
    .secStart(secStart),
    .secDeleted(secDeleted),
    .diskByte(diskByte),
    .diskValid(diskValid),
    .diskReadActive(diskReadActive)
  );

  // result byte selection by index
  logic [7:0] resByte;
  always_comb
  begin
    unique case (int'(resIdx))
      fdc_cmd_pkg::R_ST0: resByte = st0;
      fdc_cmd_pkg::R_ST1: resByte = st1;
      fdc_cmd_pkg::R_ST2: resByte = st2;
      fdc_cmd_pkg::R_CYL: resByte = cylinder[7:0];
      fdc_cmd_pkg::R_HEAD: resByte = headNum;
      fdc_cmd_pkg::R_REC: resByte = record;
      fdc_cmd_pkg::R_SIZE: resByte = sizeCode;
      default: resByte = '0;
    endcase
  end

  // status and control words seen by software
  wire logic [31:0] statWord = 32'({request_for_master, transfer_direction_bit, phase == fdc_cmd_pkg::PH_EXEC,
                     phase != fdc_cmd_pkg::PH_GATHER, cylinder[8], 3'b000});
  wire logic [31:0] ctrlWord = (32'(cylExt) << fdc_cmd_pkg::CTRL_CYL_EXT)
    | (32'(writeGateTiming) << fdc_cmd_pkg::CTRL_WG)
    | (32'(lockOn) << fdc_cmd_pkg::CTRL_LOCK)
    | (32'(fifoEnable) << fdc_cmd_pkg::CTRL_FIFO_ENABLE_BIT)
    | (32'(fifoThreshold) << fdc_cmd_pkg::CTRL_THR_LSB)
    | 32'(precompTrack);
  wire logic [7:0] dataByte = (phase == fdc_cmd_pkg::PH_EXEC) ? ex.hostByte
                                                              : resByte;
  wire logic [31:0] next_readdata = selStat ? statWord
                                  : selCtrl ? ctrlWord
                                  : selData ? {24'h00_0000, dataByte}
                                  : 32'h0000_0000;

  // bus answer: unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      served <= 1'b0;
      readdata <= '0;
    end
    else
    begin
      served <= req && !served;
      if (req && !served)
        readdata <= next_readdata;
    end
  end

  // phase sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rstn || softRst)
    begin
      phase <= fdc_cmd_pkg::PH_GATHER;
      info <= '0;
      cmdCode <= '0;
      cmdIdx <= '0;
      resIdx <= '0;
      resLen <= '0;
      execWait <= 1'b0;
      fifoFlush <= 1'b0;
    end
    else
    begin
      fifoFlush <= enterExec;
      execWait <= enterExec;
      unique case (phase)
        fdc_cmd_pkg::PH_GATHER:
          if (hostWr)
          begin
            cmdIdx <= cmdIdx + 4'h1;
            if (firstByte)
            begin
              cmdCode <= wByte;
              info <= newInfo;
            end
            if (badCode)
            begin
              phase <= fdc_cmd_pkg::PH_RESULT;
              resLen <= 4'h1;
              resIdx <= '0;
            end
            else if (lastParam)
              phase <= fdc_cmd_pkg::PH_EXEC;
          end
        fdc_cmd_pkg::PH_EXEC:
          if (!execWait && (!isRead || ex.done))
          begin
            cmdIdx <= '0;
            resIdx <= '0;
            resLen <= info.resLen;
            phase <= (info.resLen == 4'h0) ? fdc_cmd_pkg::PH_GATHER
                                            : fdc_cmd_pkg::PH_RESULT;
          end
        fdc_cmd_pkg::PH_RESULT:
          if (hostRd)
          begin
            resIdx <= resIdx + 4'h1;
            if (lastRes)
            begin
              phase <= fdc_cmd_pkg::PH_GATHER;
              cmdIdx <= '0;
            end
          end
      endcase
    end
  end

  // result contents, loaded when execution starts; a read updates record and status at its end
  always_ff @(posedge core_clk)
  begin
    if (!rstn || softRst)
    begin
      st0 <= '0;
      st1 <= '0;
      st2 <= '0;
      cylinder <= '0;
      headNum <= '0;
      record <= '0;
      sizeCode <= '0;
      driveSelect <= '0;
      headSelect <= 1'b0;
    end
    else if (badCode)
      st0 <= fdc_cmd_pkg::ST0_INVALID;
    else if (execWait)
    begin
      cylinder <= {cylExt, cmdBytes[fdc_cmd_pkg::P_CYL]};
      headNum <= cmdBytes[fdc_cmd_pkg::P_HEAD];
      record <= cmdBytes[fdc_cmd_pkg::P_REC];
      sizeCode <= cmdBytes[fdc_cmd_pkg::P_SIZE];
      driveSelect <= cmdBytes[fdc_cmd_pkg::P_DRIVE][1:0];
      headSelect <= cmdBytes[fdc_cmd_pkg::P_DRIVE][fdc_cmd_pkg::BIT_HDS];
      st0 <= {5'b00000, cmdBytes[fdc_cmd_pkg::P_DRIVE][2:0]};
      st1 <= '0;
      st2 <= '0;
      if (op == fdc_cmd_pkg::OP_LOCK)
        st0 <= {3'b000, cmdCode[fdc_cmd_pkg::BIT_LOCK], 4'h0};
    end
    else if (phase == fdc_cmd_pkg::PH_EXEC && isRead && ex.done)
    begin
      record <= ex.endRec;
      if (ex.overrun)
      begin
        st0 <= st0 | fdc_cmd_pkg::ST0_ABNORMAL;
        st1 <= fdc_cmd_pkg::ST1_OVERRUN;
      end
      if (ex.ctrlMark)
        st2 <= fdc_cmd_pkg::ST2_CTRL_MARK;
    end
  end

  // lockable settings; the lock itself is cleared only by hard reset or a lock command with bit 7 low
  wire logic cfgCmd = execWait && op == fdc_cmd_pkg::OP_CONFIGURE;
  always_ff @(posedge core_clk)
  begin
    if (!rstn || (softRst && !lockOn))
    begin
      fifoEnable <= 1'b0;
      fifoThreshold <= fdc_cmd_pkg::THR_RESET;
      precompTrack <= fdc_cmd_pkg::PRECOMP_START_TRACK_RESET;
    end
    else if (cfgCmd)
    begin
      fifoEnable <= cmdBytes[fdc_cmd_pkg::P_CFG][fdc_cmd_pkg::CFG_FIFO_ENABLE_BIT_BIT];
      fifoThreshold <= cmdBytes[fdc_cmd_pkg::P_CFG][3:0];
      precompTrack <= cmdBytes[fdc_cmd_pkg::P_PRECOMP_START_TRACK];
    end
  end

  // lock, write gate and cylinder extension settings
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      lockOn <= 1'b0;
      writeGateTiming <= 1'b0;
      cylExt <= 1'b0;
      weDelayed <= 1'b0;
    end
    else
    begin
      weDelayed <= writeGateReq;
      if (ctrlWr)
        cylExt <= writedata[fdc_cmd_pkg::CTRL_CYL_EXT];
      if (execWait && op == fdc_cmd_pkg::OP_LOCK)
        lockOn <= cmdCode[fdc_cmd_pkg::BIT_LOCK];
      if (execWait && op == fdc_cmd_pkg::OP_PERPENDICULAR)
        writeGateTiming <= cmdBytes[fdc_cmd_pkg::P_DRIVE]
                                   [fdc_cmd_pkg::PERP_WG_BIT];
    end
  end

  // write gate setting holds write enable back by one cycle
  assign writeEnable = writeGateTiming ? (writeGateReq && weDelayed)
                                       : writeGateReq;
  // precompensation from the start track outward
  assign precompEnable = cylinder >= {1'b0, precompTrack};
endmodule : floppy_cmd_phase_engine
`default_nettype wire

// ==== tb/fdc_drive_model.sv ====
// drive side model: one sector of two bytes per read execution
// assumes the engine raises diskReadActive while it wants sectors
`timescale 1ns/10ps
`default_nettype none
module fdc_drive_model (
  input wire logic core_clk,
  input wire logic active,
  input wire logic del,
  output logic secStart,
  output logic secDeleted,
  output logic [7:0] diskByte,
  output logic diskValid
);
  initial
  begin
    secStart = 1'b0;
    secDeleted = 1'b0;
    diskValid = 1'b0;
    diskByte = 8'h00;
  end
  // slow byte spacing so a polling host keeps up; stale lines inverted
  always
  begin
    @(posedge core_clk iff active === 1'b1);
    repeat (4) @(posedge core_clk);
    secStart <= 1'b1;
    secDeleted <= del;
    @(posedge core_clk);
    secStart <= 1'b0;
    secDeleted <= ~del;
    for (int i = 0; i < 2; i++)
    begin
      repeat (40) @(posedge core_clk);
      diskByte <= 8'hA5 + 8'(i);
      diskValid <= 1'b1;
      @(posedge core_clk);
      diskValid <= 1'b0;
      diskByte <= ~diskByte;
    end
    wait (active !== 1'b1);
  end
endmodule : fdc_drive_model
`default_nettype wire

// ==== tb/floppy_cmd_phase_engine_props.sv ====
// port-level assertions for the floppy command sequencer
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module floppy_cmd_phase_engine_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic writeGateReq,
  input wire logic writeEnable,
  input wire logic fifoFlush,
  input wire logic fifoEnable,
  input wire logic diskReadActive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // bus handshake: one wait cycle, none when idle
  wait_once_a: assert property ($rose(read || write) |->
    waitrequest ##1 !waitrequest) else $error("wait not one cycle");
  idle_free_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait while idle");
  rd_upper_a: assert property (read && !waitrequest |->
    readdata[31:17] == 15'h0000) else $error("upper read bits set");
  // flush is a single pulse per execution start
  flush_pulse_a: assert property (fifoFlush |=> !fifoFlush)
    else $error("flush longer than one cycle");
  // write enable never leads the request, follows a held one
  gate_req_a: assert property (writeEnable |-> writeGateReq)
    else $error("write enable without request");
  gate_held_a: assert property (writeGateReq && $past(writeGateReq)
    |-> writeEnable) else $error("held request not passed");
  exec_busy_a: assert property (read && !waitrequest && address == 4'h0
    && readdata[5] |-> readdata[4]) else $error("exec without busy");
  rst_clear_a: assert property (!$past(rstn) |-> readdata == 32'h0000_0000
    && !fifoFlush && !fifoEnable) else $error("outputs not cleared");
  cover property (fifoFlush);
  cover property ($fell(diskReadActive));
  cover property (writeGateReq && !writeEnable);
endmodule : floppy_cmd_phase_engine_props
bind floppy_cmd_phase_engine floppy_cmd_phase_engine_props props (
  .core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .writeGateReq(writeGateReq), .writeEnable(writeEnable),
  .fifoFlush(fifoFlush), .fifoEnable(fifoEnable),
  .diskReadActive(diskReadActive));
`default_nettype wire

// ==== tb/floppy_cmd_phase_engine_tb.sv ====
// self-checking bench for the floppy command sequencer
// assumes the drive model and bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module floppy_cmd_phase_engine_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic writeGateReq = 1'b0;
  logic del = 1'b0;
  logic [31:0] readdata, q;
  logic waitrequest, secStart, secDeleted, diskValid, diskReadActive;
  logic writeEnable, precompEnable, fifoFlush, fifoEnable, headSelect;
  logic [7:0] diskByte;
  logic [3:0] fifoThreshold;
  logic [1:0] driveSelect;
  int bad_count = 0;
  int n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  floppy_cmd_phase_engine uut (.core_clk(core_clk), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .secStart(secStart),
    .secDeleted(secDeleted), .diskByte(diskByte), .diskValid(diskValid),
    .writeGateReq(writeGateReq), .diskReadActive(diskReadActive),
    .writeEnable(writeEnable), .precompEnable(precompEnable),
    .fifoFlush(fifoFlush), .fifoEnable(fifoEnable),
    .fifoThreshold(fifoThreshold), .driveSelect(driveSelect),
    .headSelect(headSelect));
  fdc_drive_model drv (.core_clk(core_clk), .active(diskReadActive),
    .del(del), .secStart(secStart), .secDeleted(secDeleted),
    .diskByte(diskByte), .diskValid(diskValid));
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  // host paces every byte on the request and direction bits
  task poll(input logic transfer_direction_bit);
    do bus(1'b0, 4'h0, 8'h00); while (q[7:6] !== {1'b1, transfer_direction_bit});
  endtask : poll
  task wb(input logic [7:0] b);
    poll(1'b0);
    bus(1'b1, 4'h4, b);
  endtask : wb
  task rb(input logic [7:0] e, input logic [7:0] m = 8'hFF);
    poll(1'b1);
    bus(1'b0, 4'h4, 8'h00);
    chk(q[7:0] & m, e);
  endtask : rb
  task t_bad;
    wb(8'h1F);
    rb(8'h80);
    bus(1'b0, 4'h0, 8'h00);
    chk(q[7:0], 8'h80);
  endtask : t_bad
  // one-sector read; without draining the second byte overruns; a skipped
  // sector of the other mark kind hands no bytes to the host
  task t_read(input logic [7:0] code, input logic dl, input logic drain);
    logic [7:0] p [9];
    logic skp;
    p = '{code, 8'h05, 8'h4F, 8'h01, 8'h03, 8'h00, 8'h03, 8'h1B, 8'h02};
    skp = code[5] && ((code[4:0] == 5'h0C) != dl);
    del <= dl;
    foreach (p[i]) wb(p[i]);
    // selects load one edge after execution starts
    @(posedge core_clk);
    chk({6'h00, driveSelect}, 8'h01);
    chk({7'h00, headSelect}, 8'h01);
    if (!drain)
    begin
      @(posedge core_clk iff diskReadActive === 1'b1);
      wait (diskReadActive !== 1'b1);
    end
    if (!skp) rb(8'hA5);
    if (drain && !skp) rb(8'hA6);
    rb(drain ? 8'h00 : 8'h40, 8'h40);
    rb(drain ? 8'h00 : 8'h10);
    rb((((code[4:0] == 5'h0C) != dl) && !code[5]) ? 8'h40 : 8'h00);
    rb(8'h4F);
    rb(8'h01);
    rb(8'h03);
    rb(8'h00);
    bus(1'b0, 4'h0, 8'h00);
    chk(q[7:0], 8'h80);
  endtask : t_read
  // configure, then soft reset with and without the lock
  task t_lock;
    wb(8'h13);
    wb(8'h00);
    wb(8'h2A);
    wb(8'h30);
    // settings load one edge after execution starts
    @(posedge core_clk);
    chk({7'h00, fifoEnable}, 8'h01);
    chk({4'h0, fifoThreshold}, 8'h0A);
    wb(8'h94);
    rb(8'h10);
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b0, 4'h8, 8'h00);
    chk(q[7:0], 8'h30);
    chk({7'h00, precompEnable}, 8'h00);
    chk({7'h00, fifoEnable}, 8'h01);
    wb(8'h14);
    rb(8'h00);
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b0, 4'h8, 8'h00);
    chk(q[7:0], 8'h00);
    chk({7'h00, fifoEnable}, 8'h00);
    chk({7'h00, precompEnable}, 8'h01);
  endtask : t_lock
  // write gate on: enable lags the request by one cycle
  task t_wg;
    wb(8'h12);
    wb(8'h01);
    writeGateReq <= 1'b1;
    #1 chk({7'h00, writeEnable}, 8'h00);
    @(posedge core_clk);
    #1 chk({7'h00, writeEnable}, 8'h01);
    @(posedge core_clk);
    writeGateReq <= 1'b0;
  endtask : t_wg
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 4'h0, 8'h00);
    chk(q[7:0], 8'h80);
    bus(1'b1, 4'hC, 8'h55);
    bus(1'b0, 4'hC, 8'h00);
    chk(q[7:0], 8'h00);
    t_bad;
    t_read(8'h46, 1'b0, 1'b1);
    t_read(8'h4C, 1'b1, 1'b0);
    t_read(8'h06, 1'b1, 1'b1);
    t_read(8'h26, 1'b1, 1'b1);
    t_lock;
    t_wg;
    end_sim;
  end
  // hang guard well beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim;
  end
endmodule : floppy_cmd_phase_engine_tb
`default_nettype wire
